// File: lcdtg_pkg.sv
`default_nettype none
package lcdtg_pkg;
	// Register indices inside the 32-byte register window.
	localparam logic [4:0] REG_REVISION    = 5'h00;
	localparam logic [4:0] REG_MODE        = 5'h01;
	localparam logic [4:0] REG_HACT_WIDTH  = 5'h04;
	localparam logic [4:0] REG_VACT_LOW    = 5'h05;
	localparam logic [4:0] REG_VACT_HIGH   = 5'h06;
	localparam logic [4:0] REG_LINE_START  = 5'h07;
	localparam logic [4:0] REG_HBLANK      = 5'h08;
	localparam logic [4:0] REG_FRAME_START = 5'h09;
	localparam logic [4:0] REG_VBLANK      = 5'h0A;
	localparam logic [4:0] REG_STATUS      = 5'h0B;
	// Upper address bits that select the register window at the top of the range.
	localparam logic [11:0] WIN_TAG        = 12'hFFF;
	// Field positions.
	localparam int MODE_LINE_POL  = 4;
	localparam int MODE_FRAME_POL = 3;
	localparam int STAT_VBLANK    = 0;
	localparam int STAT_UNDERRUN  = 1;
	// Reset value of every writable register.
	localparam logic [7:0] REG_RESET   = 8'h00;
	// Revision read-back value; the value is arbitrary.
	localparam logic [7:0] REVISION_ID = 8'h5A;
	// Timing counts, in pixel clock periods unless named otherwise.
	localparam int PIX_DIV_DEF       = 2;
	localparam int HBLANK_BIAS       = 4;
	localparam int HPART_BIAS        = 16;
	localparam int LINE_PULSE_PIX    = 9;
	localparam int FRAME_LEAD_PIX    = 18;
	localparam int FRAME_PULSE_LINES = 2;
	localparam int PIX_W_DEF         = 12;
endpackage
`default_nettype wire

// File: lcdtg_top.sv
// Notes on behaviour
// - Active span lasts (width field plus one) times eight pixel clocks.
// - Horizontal blanking totals (blank field plus four) times eight pixel clocks.
// - First blanking part is start field times eight plus sixteen clocks.
// - Second blanking part is (blank minus start) times eight plus sixteen.
// - Displayed lines equal the ten-bit height value plus one.
// - Vertical blanking equals the six-bit blank field in lines.
// - First vertical blanking part lasts the frame start field in lines.
// - Second vertical blanking part lasts blank minus frame start lines.
// - Shift clock period at least one pixel clock, half high, half low.
// - Data, strobe and line pulse change half a pixel before shift falls.
// - Line pulse stays active for nine pixel clocks each line.
// - Line pulse repeats every active plus blanking pixel span.
// - Frame pulse repeats every displayed plus blanking line count.
// - Frame pulse stays active for two whole line periods.
// - Frame pulse falls one line less eighteen clocks before its line pulse.
// - Registers answer only in the top 32 bytes of the address range.
// - Line pulse is active low with polarity bit zero, else high.
`timescale 1ns/100ps
`default_nettype none
module lcdtg_top
	import lcdtg_pkg::*;
#(
	parameter int PIX_DIV = PIX_DIV_DEF,
	parameter int PIX_W   = PIX_W_DEF
) (
	// Clock and reset.
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Wishbone register port.
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [16:0]      wb_adr_i,
	input  wire logic [7:0]       wb_dat_i,
	input  wire logic [0:0]       wb_sel_i,
	output logic                  wb_ack_o,
	output logic      [7:0]       wb_dat_o,
	// Pixel stream from the frame source.
	input  wire logic [PIX_W-1:0] pix_data_i,
	input  wire logic             pix_valid_i,
	output logic                  pix_ready_o,
	// Panel pins.
	output logic                  panel_shift_clock_o,
	output logic                  line_pulse_o,
	output logic                  frame_pulse_o,
	output logic                  pixel_valid_strobe_o,
	output logic      [PIX_W-1:0] panel_pixel_bus_o
);
	localparam int DIV_W = (PIX_DIV > 2) ? $clog2(PIX_DIV) : 1;

	logic [7:0]       mode_q, hwidth_q, vlow_q, vhigh_q, lstart_q, hblank_q, fstart_q, vblank_q;
	logic             underrun_q;
	logic             req, hit, wr_hit, underrun_set;
	logic [4:0]       off;
	logic [7:0]       rd_d;
	logic [DIV_W-1:0] div_q;
	logic             pix_en;
	logic [6:0]       hw_s;
	logic [4:0]       hb_s, ls_s, ls_e;
	logic [5:0]       vb_s, fs_s, fs_e;
	logic [10:0]      vdp_s, horiz_active_span, hnd1, hnd2, htot, vtot, fl_raw, fl_w, fe_raw, fr_end;
	logic [10:0]      h_q, v_q;
	logic             h_last, v_last, disp_line, sb_d, lp_d;
	logic             lp_act_q, sb_act_q, fr_act_q;
	logic [PIX_W-1:0] buf_q [2];
	logic             wp_q, rp_q, push, pop;
	logic [1:0]       cnt_q, cnt_d;

	// Register window decode; anything outside the window is answered with zero.
	assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign hit    = (wb_adr_i[16:5] == WIN_TAG);
	assign off    = wb_adr_i[4:0];
	assign wr_hit = req & wb_we_i & wb_sel_i[0] & hit;

	// One wait state: the answer comes in the cycle after the request is seen.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 8'h00;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= (req & hit) ? rd_d : 8'h00;
		end
	end

	// Read multiplexer; the status register reflects the scan state.
	always_comb begin
		case (off)
			REG_REVISION:    rd_d = REVISION_ID;
			REG_MODE:        rd_d = mode_q;
			REG_HACT_WIDTH:  rd_d = {1'b0, hwidth_q[6:0]};
			REG_VACT_LOW:    rd_d = vlow_q;
			REG_VACT_HIGH:   rd_d = {6'h00, vhigh_q[1:0]};
			REG_LINE_START:  rd_d = {3'h0, lstart_q[4:0]};
			REG_HBLANK:      rd_d = {3'h0, hblank_q[4:0]};
			REG_FRAME_START: rd_d = {2'h0, fstart_q[5:0]};
			REG_VBLANK:      rd_d = {2'h0, vblank_q[5:0]};
			REG_STATUS:      rd_d = {6'h00, underrun_q, ~disp_line};
			default:         rd_d = 8'h00;
		endcase
	end

	// Writable configuration registers.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_q   <= REG_RESET;
			hwidth_q <= REG_RESET;
			vlow_q   <= REG_RESET;
			vhigh_q  <= REG_RESET;
			lstart_q <= REG_RESET;
			hblank_q <= REG_RESET;
			fstart_q <= REG_RESET;
			vblank_q <= REG_RESET;
		end else if (wr_hit) begin
			case (off)
				REG_MODE:        mode_q   <= wb_dat_i;
				REG_HACT_WIDTH:  hwidth_q <= wb_dat_i;
				REG_VACT_LOW:    vlow_q   <= wb_dat_i;
				REG_VACT_HIGH:   vhigh_q  <= wb_dat_i;
				REG_LINE_START:  lstart_q <= wb_dat_i;
				REG_HBLANK:      hblank_q <= wb_dat_i;
				REG_FRAME_START: fstart_q <= wb_dat_i;
				REG_VBLANK:      vblank_q <= wb_dat_i;
				default:         ;
			endcase
		end
	end

	// Sticky underrun flag; a new underrun beats a clear in the same cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			underrun_q <= 1'b0;
		end else if (underrun_set) begin
			underrun_q <= 1'b1;
		end else if (wr_hit && off == REG_STATUS && wb_dat_i[STAT_UNDERRUN]) begin
			underrun_q <= 1'b0;
		end
	end

	// Pixel clock enable divider; the shift clock is high for the first half.
	assign pix_en = (div_q == '0);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_q               <= '0;
			panel_shift_clock_o <= 1'b0;
		end else begin
			div_q <= (div_q == DIV_W'(PIX_DIV - 1)) ? '0 : div_q + 1'b1;
			if (pix_en) begin
				panel_shift_clock_o <= 1'b1;
			end else if (div_q == DIV_W'(PIX_DIV / 2)) begin
				panel_shift_clock_o <= 1'b0;
			end
		end
	end

	// Shadow copies: timing fields only take effect at a line or frame boundary, so a
	// timing register write never tears the line or frame that is being scanned.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hw_s  <= '0;
			hb_s  <= '0;
			ls_s  <= '0;
			vdp_s <= 11'h001;
			vb_s  <= '0;
			fs_s  <= '0;
		end else if (pix_en && h_last) begin
			hw_s <= hwidth_q[6:0];
			hb_s <= hblank_q[4:0];
			ls_s <= lstart_q[4:0];
			if (v_last) begin
				vdp_s <= {1'b0, vhigh_q[1:0], vlow_q} + 11'h001;
				vb_s  <= vblank_q[5:0];
				fs_s  <= fstart_q[5:0];
			end
		end
	end

	// Span arithmetic; a start field above its blank field is clamped to it.
	assign ls_e   = (ls_s > hb_s) ? hb_s : ls_s;
	assign fs_e   = (fs_s > vb_s) ? vb_s : fs_s;
	assign horiz_active_span    = {1'b0, hw_s, 3'h0} + 11'h008;
	assign hnd1   = {3'h0, ls_e, 3'h0} + 11'(HPART_BIAS);
	assign hnd2   = {3'h0, hb_s - ls_e, 3'h0} + 11'(HPART_BIAS);
	assign htot   = horiz_active_span + {3'h0, hb_s, 3'h0} + 11'(HBLANK_BIAS * 8);
	assign vtot   = vdp_s + {5'h00, vb_s};
	assign fl_raw = vdp_s + {5'h00, fs_e};
	assign fl_w   = (fl_raw >= vtot) ? fl_raw - vtot : fl_raw;
	// The rest of the blanking, blank minus start lines, begins with the pulse line.
	assign fe_raw = fl_w + 11'(FRAME_PULSE_LINES);
	assign fr_end = (fe_raw >= vtot) ? fe_raw - vtot : fe_raw;

	// Pixel and line counters run on the pixel clock enable.
	assign h_last    = (h_q == htot - 11'h001);
	assign v_last    = (v_q == vtot - 11'h001);
	assign disp_line = (v_q < vdp_s);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			h_q <= '0;
			v_q <= '0;
		end else if (pix_en) begin
			h_q <= h_last ? '0 : h_q + 11'h001;
			if (h_last) begin
				v_q <= v_last ? '0 : v_q + 11'h001;
			end
		end
	end

	// Slot 0 starts the line pulse; the strobe follows after the second part.
	assign lp_d = (h_q < 11'(LINE_PULSE_PIX));
	assign sb_d = disp_line && (h_q >= hnd2) && (h_q < hnd2 + horiz_active_span);

	// Panel outputs change with the shift clock rising edge, half a pixel
	// before the falling edge on which the panel samples them.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lp_act_q             <= 1'b0;
			sb_act_q             <= 1'b0;
			fr_act_q             <= 1'b0;
			line_pulse_o         <= 1'b1;
			frame_pulse_o        <= 1'b1;
			pixel_valid_strobe_o <= 1'b0;
			panel_pixel_bus_o    <= '0;
		end else if (pix_en) begin
			lp_act_q             <= lp_d;
			sb_act_q             <= sb_d;
			line_pulse_o         <= ~(lp_d ^ mode_q[MODE_LINE_POL]);
			pixel_valid_strobe_o <= sb_d;
			panel_pixel_bus_o    <= pop ? buf_q[rp_q] : '0;
			if (h_q == 11'(FRAME_LEAD_PIX) && v_q == fl_w) begin
				fr_act_q      <= 1'b1;
				frame_pulse_o <= mode_q[MODE_FRAME_POL];
			end else if (h_q == 11'(FRAME_LEAD_PIX) && v_q == fr_end) begin
				fr_act_q      <= 1'b0;
				frame_pulse_o <= ~mode_q[MODE_FRAME_POL];
			end
		end
	end

	// Two-entry buffer: the source may stall for one slot without a word
	// being lost, and an empty buffer during the strobe is flagged as underrun.
	assign push         = pix_valid_i & pix_ready_o;
	assign pop          = pix_en & sb_d & (cnt_q != 2'h0);
	assign underrun_set = pix_en & sb_d & (cnt_q == 2'h0);
	assign cnt_d        = cnt_q + {1'b0, push} - {1'b0, pop};
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wp_q        <= 1'b0;
			rp_q        <= 1'b0;
			cnt_q       <= 2'h0;
			pix_ready_o <= 1'b0;
		end else begin
			if (push) begin
				buf_q[wp_q] <= pix_data_i;
				wp_q        <= ~wp_q;
			end
			if (pop) begin
				rp_q <= ~rp_q;
			end
			cnt_q       <= cnt_d;
			pix_ready_o <= (cnt_d != 2'h2);
		end
	end

	// Checking helpers sample the pins one cycle after each pixel slot begins.
	logic             pen_q, lp_p, sb_p, fr_p, hv_q, fv_q, sbl_q;
	logic [10:0]      hc_q, sbf_q, h1f_q, lht_q, lc_q, fc_q, rem_q;
	logic [DIV_W:0]   hi_q;
	logic             ln_st, fr_st;
	assign ln_st = pen_q & lp_act_q & ~lp_p;
	assign fr_st = pen_q & fr_act_q & ~fr_p;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pen_q <= 1'b0;
			lp_p  <= 1'b0;
			sb_p  <= 1'b0;
			fr_p  <= 1'b0;
			hv_q  <= 1'b0;
			fv_q  <= 1'b0;
			sbl_q <= 1'b0;
			hc_q  <= '0;
			sbf_q <= '0;
			h1f_q <= '0;
			lht_q <= '0;
			lc_q  <= '0;
			fc_q  <= '0;
			rem_q <= '0;
			hi_q  <= '0;
		end else begin
			pen_q <= pix_en;
			hi_q  <= panel_shift_clock_o ? hi_q + 1'b1 : '0;
			if (pen_q) begin
				lp_p <= lp_act_q;
				sb_p <= sb_act_q;
				fr_p <= fr_act_q;
				hc_q <= ln_st ? 11'h001 : hc_q + 11'h001;
				if (sb_p & ~sb_act_q) begin
					sbf_q <= hc_q;
					h1f_q <= hnd1;
					sbl_q <= 1'b1;
				end
				if (ln_st) begin
					hv_q  <= 1'b1;
					lht_q <= htot;
					sbl_q <= 1'b0;
				end
				if (fr_st) begin
					fv_q  <= 1'b1;
					rem_q <= vtot - fl_w;
					lc_q  <= '0;
					fc_q  <= '0;
				end else if (ln_st) begin
					lc_q <= lc_q + 11'h001;
					fc_q <= fc_q + 11'h001;
				end
			end
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_shift_half_high: assert property ($fell(panel_shift_clock_o) |-> hi_q == (PIX_DIV / 2))
		else $error("shift clock high time is not half a pixel period");
	chk_pins_on_rise: assert property (($changed(panel_pixel_bus_o) || $changed(line_pulse_o)
		|| $changed(pixel_valid_strobe_o)) |-> $rose(panel_shift_clock_o))
		else $error("panel data changed away from the shift clock rising edge");
	chk_line_pulse_width: assert property (pen_q && lp_p && !lp_act_q |-> hc_q == 11'(LINE_PULSE_PIX))
		else $error("line pulse active width is not nine pixels");
	chk_line_period: assert property (ln_st && hv_q |-> hc_q == lht_q)
		else $error("line pulse period differs from active plus blanking span");
	chk_blank_second: assert property (pen_q && sb_act_q && !sb_p |-> hc_q == hnd2)
		else $error("strobe did not rise after the second blanking part");
	chk_strobe_width: assert property (pen_q && sb_p && !sb_act_q |-> hc_q == hnd2 + horiz_active_span)
		else $error("strobe width differs from the active span");
	chk_blank_first: assert property (ln_st && sbl_q |-> hc_q - sbf_q == h1f_q)
		else $error("first blanking part has the wrong length");
	chk_frame_lead: assert property (fr_st |-> hc_q == 11'(FRAME_LEAD_PIX) && !lp_act_q)
		else $error("frame pulse edge is not eighteen pixels after the line start");
	chk_frame_width: assert property (pen_q && fr_p && !fr_act_q
		|-> lc_q == 11'(FRAME_PULSE_LINES))
		else $error("frame pulse active width is not two lines");
	chk_frame_period: assert property (fr_st && fv_q |-> fc_q == rem_q + fl_w)
		else $error("frame pulse period differs from the line total");
	// A frame with no blanking lines wraps the pulse line back to zero, so skip it.
	chk_frame_start: assert property (fr_st && vb_s != 6'h00 |-> v_q - vdp_s == {5'h00, fs_e})
		else $error("first vertical blanking part has the wrong length");
	chk_line_polarity: assert property (pen_q |->
		line_pulse_o == (lp_act_q ~^ $past(mode_q[MODE_LINE_POL])))
		else $error("line pulse polarity does not follow the mode bit");
	chk_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered in the next cycle");
	chk_window_miss: assert property (req && !hit |=> wb_dat_o == 8'h00)
		else $error("address outside the register window returned data");
endmodule // lcdtg_top
`default_nettype wire

// File: lcdtg_panel_model.sv
`timescale 1ns/100ps
`default_nettype none
// Panel row and column drivers; every pin is sampled on the falling shift clock edge.
module lcdtg_panel_model (
	// Panel pins.
	input  wire logic        sclk_i,
	input  wire logic        line_i,
	input  wire logic        frame_i,
	input  wire logic        dv_i,
	input  wire logic [11:0] pix_i,
	// Line pulse polarity in use, high for active high.
	input  wire logic        lpol_i,
	// Measurements in pixel slots, lines or counts.
	output int               line_per_o,
	output int               line_wid_o,
	output int               dv_lead_o,
	output int               dv_wid_o,
	output int               frm_lines_o,
	output int               frm_wid_o,
	output int               frm_lead_o,
	output int               vb1_o,
	output int               vb2_o,
	output int               dv_lines_o,
	output int               nfr_o,
	output int               pix_err_o
);
	int          n, tl, tf, td, c1, c2, nd, nl, fl;
	logic        pl, pf, pd, fp1, fp2, seen, la;
	logic [11:0] last;

	// The panel sees only falling shift edges, so a late pin shows up as a wrong count.
	always @(negedge sclk_i) begin
		n = n + 1;
		la = line_i ^ lpol_i;
		if (!la && pl) begin
			line_per_o = n - tl;
			tl = n;
			c1++;
			c2++;
			nl++;
			if (fp1) begin
				frm_lead_o = n - tf;
				fp1 = 1'b0;
			end
		end
		if (la && !pl) line_wid_o = n - tl;
		if (dv_i && !pd) begin
			dv_lead_o = n - tl;
			td = n;
			c1 = 0;
			nd++;
			if (fp2) begin
				vb2_o = c2;
				fp2 = 1'b0;
			end
		end
		if (!dv_i && pd) dv_wid_o = n - td;
		if (dv_i) begin
			if (seen && pix_i !== last + 12'h001) pix_err_o++;
			last = pix_i;
			seen = 1'b1;
		end
		if (!frame_i && pf) begin
			frm_lines_o = nl - fl;
			fl = nl;
			vb1_o = c1;
			dv_lines_o = nd;
			nd = 0;
			c2 = 0;
			tf = n;
			fp1 = 1'b1;
			fp2 = 1'b1;
			nfr_o++;
		end
		if (frame_i && !pf) frm_wid_o = n - tf;
		pl = la;
		pd = dv_i;
		pf = frame_i;
	end
endmodule // lcdtg_panel_model
`default_nettype wire

// File: lcdtg_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
	$display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module lcdtg_top_bench;
	import lcdtg_pkg::*;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, lpol = 1'b0;
	logic [16:0] adr = 17'h00000;
	logic [7:0]  wdat = 8'h00, rd, wb_dat_o;
	logic [11:0] pix_data = 12'h000, pix_o;
	logic        wb_ack_o, rdy, sclk, lp, fp, dv;
	int          num_errors = 0, compares = 0, tk = 0;
	int          lper, lwid, dlead, dwid, flines, fwid, flead, vb1, vb2, dlines, nfr, perr;

	// Clock at 40 MHz.
	always #12.5 clk_i = ~clk_i;

	// Source always offers a word, so the buffer is full whenever the panel is not draining it.
	always @(posedge clk_i) begin
		if (rdy === 1'b1) begin
			pix_data <= pix_data + 12'h001;
			tk <= tk + 1;
		end
	end

	lcdtg_top lcdtg_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(1'b1), .wb_ack_o(wb_ack_o),
		.wb_dat_o(wb_dat_o), .pix_data_i(pix_data), .pix_valid_i(1'b1), .pix_ready_o(rdy),
		.panel_shift_clock_o(sclk), .line_pulse_o(lp), .frame_pulse_o(fp),
		.pixel_valid_strobe_o(dv), .panel_pixel_bus_o(pix_o));

	lcdtg_panel_model lcdtg_panel_model_i (.sclk_i(sclk), .line_i(lp), .frame_i(fp), .dv_i(dv),
		.pix_i(pix_o), .lpol_i(lpol), .line_per_o(lper), .line_wid_o(lwid), .dv_lead_o(dlead),
		.dv_wid_o(dwid), .frm_lines_o(flines), .frm_wid_o(fwid), .frm_lead_o(flead),
		.vb1_o(vb1), .vb2_o(vb2), .dv_lines_o(dlines), .nfr_o(nfr), .pix_err_o(perr));

	task report_and_stop;
		if (num_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// One classic cycle; the answer time is not assumed, only bounded.
	task automatic wb(input logic w, input logic [16:0] a, input logic [7:0] d);
		int k;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		for (k = 0; k < 16; k++) begin
			@(posedge clk_i);
			if (wb_ack_o === 1'b1) break;
		end
		rd = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (k == 16) begin
			num_errors++;
			report_and_stop;
		end
	endtask

	task automatic wait_frames(input int f);
		int k, s;
		s = nfr;
		for (k = 0; k < 3000 * f && nfr < s + f; k++) @(posedge clk_i);
		if (nfr < s + f) begin
			num_errors++;
			report_and_stop;
		end
	endtask

	// Two words fill the buffer long before the first strobe slot drains it.
	task t_fill;
		repeat (5) @(posedge clk_i);
		@(negedge clk_i);
		`CHK("ready_full", 1'b0, rdy)
		`CHK("words_taken", 2, tk)
	endtask

	// Only the top 32 bytes decode; anything else reads zero and ignores writes.
	task t_regs;
		wb(1'b0, 17'h1FFE0, 8'h00);
		`CHK("revision", REVISION_ID, rd)
		wb(1'b1, 17'h00004, 8'hFF);
		wb(1'b0, 17'h00004, 8'h00);
		`CHK("outside_read", 8'h00, rd)
		wb(1'b0, 17'h1FFE4, 8'h00);
		`CHK("width_kept", 8'h01, rd)
		wb(1'b0, 17'h1FFFF, 8'h00);
		`CHK("unmapped", 8'h00, rd)
		wb(1'b0, 17'h1FFEB, 8'h00);
		`CHK("underrun_clear", 1'b0, rd[STAT_UNDERRUN])
	endtask

	// Width 1, blank 2, line start 1, three lines, vblank 3, frame start 2.
	task t_timing;
		wait_frames(3);
		`CHK("line_period", 64, lper)
		`CHK("blank_total", 48, lper - dwid)
		`CHK("strobe_width", 16, dwid)
		`CHK("blank_second", 24, dlead)
		`CHK("blank_first", 24, lper - dlead - dwid)
		`CHK("line_width", 9, lwid)
		`CHK("frame_lines", 6, flines)
		`CHK("shown_lines", 3, dlines)
		`CHK("vblank_first", 3, vb1)
		`CHK("vblank_second", 1, vb2)
		`CHK("frame_width", 128, fwid)
		`CHK("frame_lead", 46, flead)
		`CHK("pixel_order", 0, perr)
	endtask

	// The shift clock halves each slot and pins never move at its falling edge.
	task t_shift;
		logic [15:0] pv;
		logic        ps;
		int          i;
		@(negedge clk_i);
		pv = {lp, fp, dv, pix_o};
		ps = sclk;
		for (i = 0; i < 40; i++) begin
			@(negedge clk_i);
			`CHK("shift_toggle", ~ps, sclk)
			if (sclk === 1'b0) `CHK("pins_stable", pv, {lp, fp, dv, pix_o})
			pv = {lp, fp, dv, pix_o};
			ps = sclk;
		end
	endtask

	// Flipping the line polarity keeps the nine-slot pulse, now active high.
	task t_polarity;
		wb(1'b1, 17'h1FFE1, 8'h10);
		lpol = 1'b1;
		wait_frames(2);
		`CHK("line_width_high", 9, lwid)
		`CHK("line_period_high", 64, lper)
	endtask

	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		t_fill;
		wb(1'b1, 17'h1FFE4, 8'h01);
		wb(1'b1, 17'h1FFE5, 8'h02);
		wb(1'b1, 17'h1FFE6, 8'h00);
		wb(1'b1, 17'h1FFE7, 8'h01);
		wb(1'b1, 17'h1FFE8, 8'h02);
		wb(1'b1, 17'h1FFE9, 8'h02);
		wb(1'b1, 17'h1FFEA, 8'h03);
		t_regs;
		t_timing;
		t_shift;
		t_polarity;
		report_and_stop;
	end
endmodule // lcdtg_top_bench
`default_nettype wire
